// ### logic/rtc_alarm_map.vh
/*
  register offsets, field positions, reset values and timing counts of the
  alarm 0 and backup bus gating block.
  assumes it is included by bare name from the files under logic/.
*/
`ifndef RTC_ALARM_MAP_VH
`define RTC_ALARM_MAP_VH

// ----------------------------------------------------------------------
// register sub-addresses on the serial bus
// ----------------------------------------------------------------------
`define RTC_REG_SEC 8'h00
`define RTC_REG_MIN 8'h01
`define RTC_REG_HOUR 8'h02
`define RTC_REG_DATE 8'h03
`define RTC_REG_MONTH 8'h04
`define RTC_REG_WDAY 8'h05
`define RTC_REG_INT 8'h06
`define RTC_REG_STATUS 8'h07
`define RTC_REG_PWR 8'h08

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTC_FIELD_EN_BIT 7
`define RTC_INT_IM_BIT 7
`define RTC_INT_ALARM0_ENABLE_BIT 5
`define RTC_STAT_AL0_BIT 0
`define RTC_STAT_BACKUP_BIT 1
`define RTC_PWR_BSW_BIT 0
`define RTC_PWR_SERIAL_BUS_IN_BACKUP_BIT 1

// ----------------------------------------------------------------------
// reset values and bus address
// ----------------------------------------------------------------------
`define RTC_RESET_BYTE 8'h00
// bus address value is arbitrary
`define RTC_SLAVE_ADDR 7'h50

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RTC_MCLK_MHZ 20
`define RTC_IRQ_PULSE_US 1000
// pulse length in mclk cycles: RTC_IRQ_PULSE_US at RTC_MCLK_MHZ, sized to the counter
`define RTC_IRQ_PULSE_CYC 15'h4e20

`endif

// ### logic/alarm_match.v
/*
  combinational comparator of the six alarm 0 fields against the running
  calendar.
  assumes calendar values are bcd and come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "rtc_alarm_map.vh"

module alarm_match (
  input wire [47:0] alarm_fields,
  input wire [47:0] time_fields,
  output wire match
);

  // ----------------------------------------------------------------------
  // per-field compare
  // ----------------------------------------------------------------------
  wire [5:0] field_en; // msb of each alarm byte
  wire [5:0] field_eq; // low bits equal, or field left out

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_field
      assign field_en[gi] = alarm_fields[gi*8+`RTC_FIELD_EN_BIT];
      // a cleared enable bit drops the field from the compare
      assign field_eq[gi] = ~field_en[gi] |
        (alarm_fields[gi*8+6:gi*8] == time_fields[gi*8+6:gi*8]);
    end
  endgenerate

  // all enabled fields at once; an all-disabled alarm never fires
  assign match = (&field_eq) & (|field_en);

endmodule // alarm_match

// ### logic/rtc_alarm_gate.v
/*
  serial bus slave with alarm 0 match, interrupt output and backup bus gating.
  assumes supply comparator levels and bus pins are asynchronous to mclk, and
  the calendar values with their advance pulse come from mclk logic.
*/
// Contract
// - no bus response below reset threshold
// - two bits select four switchover modes
// - backup bus only in legacy, bus-in-backup clear
// - backup eeprom access only in legacy mode
// - standard modes drop bus on backup entry
// - legacy-off mode needs supply above both
// - field msb enables, low bits match value
// - full match sets flag, drives interrupt low
// - alarm event only with alarm enable set
// - mode clear gives single held interrupt
// - mode set pulses interrupt every match
// - pulsed mode sets flag, needs no clear
// - power-up defaults to standard backup mode
`timescale 1ns/1ps
`include "rtc_alarm_map.vh"

module rtc_alarm_gate #(
  parameter [14:0] PULSE_CYCLES = `RTC_IRQ_PULSE_CYC
) (
  input wire mclk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire vdd_above_reset,
  input wire vbat_above_reset,
  input wire vdd_above_vbat,
  input wire vdd_above_trip,
  input wire time_tick,
  input wire [7:0] cur_sec,
  input wire [7:0] cur_min,
  input wire [7:0] cur_hour,
  input wire [7:0] cur_date,
  input wire [7:0] cur_month,
  input wire [7:0] cur_wday,
  output reg irq_freq_out,
  output reg irq_freq_out_oe,
  output reg alarm0_flag,
  output reg on_backup,
  output reg bus_enabled,
  output reg eeprom_allowed
);

  // ----------------------------------------------------------------------
  // states of the bus slave
  // ----------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'b000_0001;
  localparam [6:0] S_ADDR = 7'b000_0010;
  localparam [6:0] S_AACK = 7'b000_0100;
  localparam [6:0] S_RX = 7'b000_1000;
  localparam [6:0] S_RACK = 7'b001_0000;
  localparam [6:0] S_TX = 7'b010_0000;
  localparam [6:0] S_TACK = 7'b100_0000;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  reg [5:0] sync1_q; // first stage, read only by sync2_q
  reg [5:0] sync2_q; // settled levels
  reg scl_last_q; // previous settled clock for edge finding
  reg sda_last_q; // previous settled data for start and stop

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // bus pins reset to their idle high level so no false edge follows reset
      sync1_q <= 6'h03;
      sync2_q <= 6'h03;
      scl_last_q <= 1'b1;
      sda_last_q <= 1'b1;
    end else begin
      sync1_q <= {vdd_above_trip, vdd_above_vbat, vbat_above_reset,
                  vdd_above_reset, sda_in, scl_in};
      sync2_q <= sync1_q;
      scl_last_q <= sync2_q[0];
      sda_last_q <= sync2_q[1];
    end
  end

  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire vdd_ok = sync2_q[2]; // main supply above reset threshold
  wire vbat_ok = sync2_q[3]; // backup supply above reset threshold
  wire vdd_gt_bat = sync2_q[4];
  wire vdd_gt_trip = sync2_q[5];
  wire scl_rise = scl_s & ~scl_last_q;
  wire scl_fall = ~scl_s & scl_last_q;
  wire bus_start = scl_s & scl_last_q & sda_last_q & ~sda_s;
  wire bus_stop = scl_s & scl_last_q & ~sda_last_q & sda_s;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [7:0] al_sec_q, al_min_q, al_hour_q, al_date_q, al_month_q, al_wday_q;
  reg [7:0] int_ctrl_q; // interrupt control
  reg [1:0] pwr_ctrl_q; // switchover select and bus-in-backup bits
  reg bus_ok_q; // gating decision, one cycle behind the synced levels

  wire sw_sel = pwr_ctrl_q[`RTC_PWR_BSW_BIT];
  wire bib = pwr_ctrl_q[`RTC_PWR_SERIAL_BUS_IN_BACKUP_BIT];
  wire int_mode = int_ctrl_q[`RTC_INT_IM_BIT];
  wire al0_en = int_ctrl_q[`RTC_INT_ALARM0_ENABLE_BIT];

  // ----------------------------------------------------------------------
  // supply mode and bus gating
  // ----------------------------------------------------------------------
  reg backup_d, bus_ok_d, ee_ok_d;

  always @* begin
    // legacy switches when main supply drops below backup, standard at trip
    backup_d = sw_sel ? ~vdd_gt_bat : ~vdd_gt_trip;
    if (!vdd_ok) begin
      bus_ok_d = 1'b0;
    end else if (sw_sel && !bib) begin
      bus_ok_d = ~backup_d | vbat_ok;
    end else if (sw_sel) begin
      bus_ok_d = vdd_gt_bat;
    end else begin
      bus_ok_d = ~backup_d;
    end
    // only the legacy mode with bus-in-backup clear keeps eeprom on backup
    ee_ok_d = ~backup_d | (sw_sel & ~bib);
  end

  // ----------------------------------------------------------------------
  // read mux, decoded by sub-address
  // ----------------------------------------------------------------------
  reg [7:0] ptr_q;
  reg [7:0] rdata;

  always @* begin
    if (ptr_q == `RTC_REG_SEC) rdata = al_sec_q;
    else if (ptr_q == `RTC_REG_MIN) rdata = al_min_q;
    else if (ptr_q == `RTC_REG_HOUR) rdata = al_hour_q;
    else if (ptr_q == `RTC_REG_DATE) rdata = al_date_q;
    else if (ptr_q == `RTC_REG_MONTH) rdata = al_month_q;
    else if (ptr_q == `RTC_REG_WDAY) rdata = al_wday_q;
    else if (ptr_q == `RTC_REG_INT) rdata = int_ctrl_q;
    else if (ptr_q == `RTC_REG_STATUS) rdata = {6'h00, on_backup, alarm0_flag};
    else if (ptr_q == `RTC_REG_PWR) rdata = {6'h00, pwr_ctrl_q};
    else rdata = 8'h00; // unmapped reads as zero
  end

  // ----------------------------------------------------------------------
  // bus slave: shifts on clock rise, drives data on clock fall
  // ----------------------------------------------------------------------
  reg [6:0] state_q;
  reg [2:0] bit_q; // bit count within the byte
  reg [7:0] shift_q;
  reg first_q; // next written byte is the sub-address
  reg ack_hold_q; // ack slot driven, release on next fall
  reg rd_q; // transfer is a read
  reg wr_stb; // one-cycle write strobe
  reg status_rd; // status byte loaded for sending
  wire [7:0] shift_in = {shift_q[6:0], sda_s};

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      bit_q <= 3'd0;
      shift_q <= 8'h00;
      first_q <= 1'b0;
      ack_hold_q <= 1'b0;
      rd_q <= 1'b0;
      ptr_q <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      status_rd <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      status_rd <= 1'b0;
      sda_out <= 1'b0;
      if (!bus_ok_q) begin
        // gated off: drop any transfer and let go of the line
        state_q <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_q <= S_ADDR;
        bit_q <= 3'd0;
        first_q <= 1'b1;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR: begin
            if (scl_rise) begin
              shift_q <= shift_in;
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                rd_q <= sda_s;
                ack_hold_q <= 1'b0;
                // foreign address: stay silent until the next start
                state_q <= (shift_q[6:0] == `RTC_SLAVE_ADDR) ? S_AACK : S_IDLE;
              end
            end
          end
          S_AACK, S_RACK: begin
            if (scl_fall && !ack_hold_q) begin
              sda_oe <= 1'b1; // ack is a driven low
              ack_hold_q <= 1'b1;
            end else if (scl_fall) begin
              bit_q <= 3'd0;
              if (rd_q && state_q == S_AACK) begin
                sda_oe <= ~rdata[7];
                shift_q <= {rdata[6:0], 1'b0};
                status_rd <= (ptr_q == `RTC_REG_STATUS);
                state_q <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                state_q <= S_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_q <= shift_in;
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                ack_hold_q <= 1'b0;
                state_q <= S_RACK;
                if (first_q) begin
                  ptr_q <= shift_in;
                  first_q <= 1'b0;
                end else begin
                  wr_stb <= 1'b1;
                end
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              // open drain: a one is sent by letting go
              sda_oe <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end else if (scl_rise) begin
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                ptr_q <= ptr_q + 8'h01;
                state_q <= S_TACK;
              end
            end
          end
          default: begin
            if (state_q == S_TACK && scl_fall) begin
              sda_oe <= 1'b0; // leave the ack slot to the master
            end else if (state_q == S_TACK && scl_rise) begin
              bit_q <= 3'd0;
              if (sda_s) begin
                state_q <= S_IDLE; // master refused: read ends
              end else begin
                shift_q <= rdata;
                status_rd <= (ptr_q == `RTC_REG_STATUS);
                state_q <= S_TX;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // register writes land at the pointer; only read bytes advance it
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      al_sec_q <= `RTC_RESET_BYTE;
      al_min_q <= `RTC_RESET_BYTE;
      al_hour_q <= `RTC_RESET_BYTE;
      al_date_q <= `RTC_RESET_BYTE;
      al_month_q <= `RTC_RESET_BYTE;
      al_wday_q <= `RTC_RESET_BYTE;
      int_ctrl_q <= `RTC_RESET_BYTE;
      pwr_ctrl_q <= 2'b00; // standard switchover after power-up
    end else if (wr_stb) begin
      if (ptr_q == `RTC_REG_SEC) al_sec_q <= shift_q;
      else if (ptr_q == `RTC_REG_MIN) al_min_q <= shift_q;
      else if (ptr_q == `RTC_REG_HOUR) al_hour_q <= shift_q;
      else if (ptr_q == `RTC_REG_DATE) al_date_q <= shift_q;
      else if (ptr_q == `RTC_REG_MONTH) al_month_q <= shift_q;
      else if (ptr_q == `RTC_REG_WDAY) al_wday_q <= shift_q;
      else if (ptr_q == `RTC_REG_INT) int_ctrl_q <= shift_q;
      else if (ptr_q == `RTC_REG_PWR) pwr_ctrl_q <= shift_q[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // alarm compare and interrupt
  // ----------------------------------------------------------------------
  wire match;
  alarm_match u_match (
    .alarm_fields({al_wday_q, al_month_q, al_date_q, al_hour_q, al_min_q, al_sec_q}),
    .time_fields({cur_wday, cur_month, cur_date, cur_hour, cur_min, cur_sec}),
    .match(match)
  );

  // only on the advance of the time, so a held match fires once per advance
  wire trigger = time_tick & match & al0_en;
  reg [14:0] pulse_q; // remaining cycles of the interrupt pulse

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm0_flag <= 1'b0;
      pulse_q <= 15'h0000;
      irq_freq_out <= 1'b0;
      irq_freq_out_oe <= 1'b0;
      on_backup <= 1'b0;
      bus_ok_q <= 1'b0;
      bus_enabled <= 1'b0;
      eeprom_allowed <= 1'b0;
    end else begin
      // set wins over the clear from a status read
      if (trigger) alarm0_flag <= 1'b1;
      else if (status_rd) alarm0_flag <= 1'b0;
      if (trigger && int_mode) pulse_q <= PULSE_CYCLES;
      else if (pulse_q != 15'h0000) pulse_q <= pulse_q - 15'h0001;
      irq_freq_out <= 1'b0;
      // pulsed mode ignores the flag; single mode holds low until cleared
      irq_freq_out_oe <= int_mode ? ((trigger | (pulse_q > 15'h0001)))
                                  : (alarm0_flag | trigger);
      on_backup <= backup_d;
      bus_ok_q <= bus_ok_d;
      bus_enabled <= bus_ok_d;
      eeprom_allowed <= ee_ok_d;
    end
  end

endmodule // rtc_alarm_gate

// ### bench/rtc_alarm_gate_asserts.sv
/* pin assertions of the alarm and backup bus gating block.
   assumes a bind to rtc_alarm_gate; sees its ports only. */
`timescale 1ns/1ps
module rtc_alarm_gate_asserts #(
  parameter [14:0] PULSE_CYCLES = 15'h4e20
) (
  input wire mclk,
  input wire reset_n,
  input wire vdd_above_reset,
  input wire vbat_above_reset,
  input wire time_tick,
  input wire sda_out,
  input wire sda_oe,
  input wire irq_freq_out,
  input wire irq_freq_out_oe,
  input wire alarm0_flag,
  input wire on_backup,
  input wire bus_enabled,
  input wire eeprom_allowed
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // cycles the interrupt pin has been held low so far
  reg [15:0] hi_cnt_q;
  wire [15:0] hi_cnt_d = irq_freq_out_oe ? hi_cnt_q + 16'h0001 : 16'h0000;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_q <= 16'h0000;
    end else begin
      hi_cnt_q <= hi_cnt_d;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_open_drain_pins: assert property (!sda_out && !irq_freq_out)
    else $error("open-drain pin driven high");
  a_no_bus_low_vdd: assert property ((!vdd_above_reset)[*8] |-> !bus_enabled && !sda_oe)
    else $error("bus alive below reset level");
  a_backup_bus_off: assert property ((on_backup && !vbat_above_reset)[*6] |-> !bus_enabled)
    else $error("bus alive on weak backup");
  a_flag_from_tick: assert property ($rose(alarm0_flag) |-> $past(time_tick))
    else $error("flag set without a calendar step");
  a_irq_with_flag: assert property ($rose(irq_freq_out_oe) |->
    alarm0_flag && $past(time_tick))
    else $error("interrupt without flag or step");
  a_pulse_width: assert property ($fell(irq_freq_out_oe) && alarm0_flag |->
    hi_cnt_q == {1'b0, PULSE_CYCLES})
    else $error("interrupt pulse width wrong");
  a_ack_needs_bus: assert property ($rose(sda_oe) |-> $past(bus_enabled))
    else $error("sda pulled while bus gated");
  a_eeprom_off_backup: assert property ($fell(on_backup) |-> ##[0:2] eeprom_allowed)
    else $error("eeprom gated on main supply");
  c_alarm: cover property ($rose(alarm0_flag));
  c_pulse: cover property ($fell(irq_freq_out_oe) && alarm0_flag);
  c_bus_off: cover property ($fell(bus_enabled));
endmodule // rtc_alarm_gate_asserts

bind rtc_alarm_gate rtc_alarm_gate_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_asserts (
  .mclk(mclk), .reset_n(reset_n), .vdd_above_reset(vdd_above_reset),
  .vbat_above_reset(vbat_above_reset), .time_tick(time_tick), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq_freq_out(irq_freq_out), .irq_freq_out_oe(irq_freq_out_oe),
  .alarm0_flag(alarm0_flag), .on_backup(on_backup), .bus_enabled(bus_enabled),
  .eeprom_allowed(eeprom_allowed));

// ### bench/rtc_host_model.sv
/* serial bus master standing in for the host controller.
   assumes the bench resolves the open-drain sda wire with a pull-up. */
`timescale 1ns/1ps
`include "rtc_alarm_map.vh"
module rtc_host_model (
  input wire mclk,
  input wire sda_w,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // bus primitives, scl period 8 mclk
  // ----------------------------------------
  initial begin
    scl = 1'b1; // clock stands high between frames
    sda_low = 1'b0; // released: pull-up holds sda high
  end
  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // data moves a cycle after scl falls, so it never races the clock edge
  task automatic slot(input logic b, output logic s);
    gap(1);
    sda_low = !b;
    gap(3);
    scl = 1'b1;
    gap(2);
    s = sda_w;
    gap(2);
    scl = 1'b0;
  endtask
  task automatic start();
    gap(4);
    sda_low = 1'b1; // sda falls while scl high
    gap(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    gap(1);
    sda_low = 1'b1;
    gap(3);
    scl = 1'b1;
    gap(4);
    sda_low = 1'b0; // sda rises while scl high
    gap(4);
  endtask
  // eight bits msb first, then the ninth slot carrying n
  task automatic xbyte(input logic [7:0] d, input logic n,
                       output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(n, s);
    ack = !s;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xbyte({`RTC_SLAVE_ADDR, 1'b0}, 1'b1, q, k0);
    xbyte(a, 1'b1, q, k1);
    xbyte(d, 1'b1, q, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask
  // pointer set, repeated start, two bytes read: ack after the first, nack after the second
  task automatic read_pair(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] q;
    logic k;
    start();
    xbyte({`RTC_SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    xbyte(a, 1'b1, q, k);
    // let sda go and raise scl first, so the start can drop sda while scl is high
    gap(1);
    sda_low = 1'b0;
    gap(3);
    scl = 1'b1;
    start();
    xbyte({`RTC_SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    xbyte(8'hff, 1'b0, d[15:8], k);
    xbyte(8'hff, 1'b1, d[7:0], k);
    stop();
  endtask
  // pointer set by a short write, then one byte read and refused with nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    start();
    xbyte({`RTC_SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    xbyte(a, 1'b1, q, k);
    stop();
    start();
    xbyte({`RTC_SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    xbyte(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule // rtc_host_model

// ### bench/rtc_alarm_gate_bench.sv
/* self-checking bench of the alarm 0 and backup bus gating block.
   assumes rtc_host_model as bus master and the bound checker. */
`timescale 1ns/1ps
`include "rtc_alarm_map.vh"
module rtc_alarm_gate_bench;
  logic mclk = 1'b0; // 20 MHz
  logic reset_n = 1'b0;
  logic time_tick = 1'b0;
  logic [3:0] sup = 4'hf; // vdd ok, vbat ok, vdd above vbat, vdd above trip
  logic [47:0] ct = 48'h0000_0000_0000; // sec min hour date month wday
  logic [7:0] rd;
  logic [15:0] rw; // two bytes of a burst read
  logic ok;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  wire scl, sda_low, sda_out, sda_oe, irq_out, irq_oe, flag, on_bk, bus_en, ee_ok;
  wire sda_w = !(sda_low || sda_oe);
  initial begin
    forever #25 mclk = ~mclk;
  end
  rtc_alarm_gate #(.PULSE_CYCLES(15'h0008)) dut (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .vdd_above_reset(sup[3]), .vbat_above_reset(sup[2]),
    .vdd_above_vbat(sup[1]), .vdd_above_trip(sup[0]), .time_tick(time_tick),
    .cur_sec(ct[47:40]), .cur_min(ct[39:32]), .cur_hour(ct[31:24]),
    .cur_date(ct[23:16]), .cur_month(ct[15:8]), .cur_wday(ct[7:0]),
    .irq_freq_out(irq_out), .irq_freq_out_oe(irq_oe), .alarm0_flag(flag),
    .on_backup(on_bk), .bus_enabled(bus_en), .eeprom_allowed(ee_ok));
  rtc_host_model host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    check(ok, 1'b1);
  endtask
  // one calendar step; returns once the cycle after it has landed
  task automatic tick(input logic [47:0] t);
    @(negedge mclk);
    ct = t;
    time_tick = 1'b1;
    @(negedge mclk);
    time_tick = 1'b0;
    @(negedge mclk);
  endtask
  task automatic set_alarm(input logic [47:0] a, input logic [7:0] ic);
    for (int i = 0; i < 6; i++) wr(`RTC_REG_SEC + 8'(i), a[47 - 8 * i -: 8]);
    wr(`RTC_REG_INT, ic);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    check({on_bk, bus_en, ee_ok, irq_oe}, 4'b0110);
    host.read_reg(`RTC_REG_PWR, rd);
    check(rd, 8'h00);
    host.read_reg(8'h0f, rd); // unmapped place reads zero
    check(rd, 8'h00);
  endtask
  task automatic t_single();
    set_alarm(48'h00b0_9181_8100, 8'h20);
    host.read_pair(`RTC_REG_MIN, rw);
    check(rw[15:8], 8'hb0);
    check(rw[7:0], 8'h91);
    tick(48'h0030_1101_0204); // month differs
    check({flag, irq_oe}, 2'b00);
    tick(48'h0030_1101_0104);
    check({flag, irq_oe}, 2'b11);
    tick(48'h0130_1101_0104);
    repeat (20) @(negedge mclk);
    check(irq_oe, 1'b1);
    host.read_reg(`RTC_REG_STATUS, rd);
    check(rd, 8'h01);
    check({flag, irq_oe}, 2'b00);
  endtask
  task automatic t_enable();
    wr(`RTC_REG_INT, 8'h00);
    tick(48'h0030_1101_0104);
    check({flag, irq_oe}, 2'b00);
    set_alarm(48'h0000_0000_0000, 8'h20);
    tick(48'h0000_0000_0000);
    check({flag, irq_oe}, 2'b00);
  endtask
  // pulses repeat while the flag is never cleared
  task automatic t_pulse();
    set_alarm(48'hb000_0000_0000, 8'ha0);
    for (int k = 0; k < 2; k++) begin
      tick(48'h3059_2331_1206);
      check({flag, irq_oe}, 2'b11);
      repeat (8) @(negedge mclk);
      check({flag, irq_oe}, 2'b10);
    end
  endtask
  // every mode against four supply states, bus tried at the pins each time
  task automatic t_gating();
    logic [3:0] cs [4] = '{4'b1101, 4'b1110, 4'b0111, 4'b1001};
    logic bk, bus, ee;
    for (int m = 0; m < 4; m++) begin
      wr(`RTC_REG_PWR, 8'(m));
      foreach (cs[c]) begin
        sup = cs[c];
        repeat (8) @(negedge mclk);
        bk = m[0] ? !sup[1] : !sup[0];
        bus = sup[3] && (m[0] ? (m[1] ? sup[1] : !bk || sup[2]) : !bk);
        ee = !bk || (m[0] && !m[1]);
        check({on_bk, bus_en, ee_ok}, {bk, bus, ee});
        host.write_reg(`RTC_REG_INT, 8'ha0, ok);
        check(ok, bus);
        sup = 4'hf;
        repeat (8) @(negedge mclk);
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    t_defaults();
    t_single();
    t_enable();
    t_pulse();
    t_gating();
    report_and_stop();
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
endmodule // rtc_alarm_gate_bench
